// ### shared/ppm_pkg.sv
// package for the power-management capability register bank
package ppm_pkg;
    // configuration byte offsets
    localparam logic [7:0] OFS_CAPS = 8'hA2;
    localparam logic [7:0] OFS_CSR = 8'hA4;
    localparam logic [7:0] OFS_BSE = 8'hA6;
    // capabilities word field positions
    localparam int CAP_WAKE_D3COLD = 15;
    localparam int CAP_AUX_POWER = 4;
    localparam int CAP_DSI = 5;
    localparam int CAP_NEEDS_CLK = 3;
    // capability reset value of the writable D3cold wake bit
    localparam logic CAP_WAKE_D3COLD_RST = 1'b1;
    // fixed high capability bits 14..9, low bits 8..6 zero
    localparam logic [15:0] CAP_FIXED = 16'h7E00;
    // version codes
    localparam logic [2:0] VER_REV11 = 3'h2;
    localparam logic [2:0] VER_REV12 = 3'h3;
    // control/status field positions
    localparam int CSR_STATUS = 15;
    localparam int CSR_ENABLE = 8;
    localparam logic [15:0] CSR_RST = 16'h0000;
    // bridge extension fixed value
    localparam logic [7:0] BSE_VALUE = 8'hC0;
    // power states
    typedef enum logic [1:0] {
        PS_D0 = 2'b00,
        PS_D1 = 2'b01,
        PS_D2 = 2'b10,
        PS_D3HOT = 2'b11
    } ppm_pstate_t;
    // configuration access from the host side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } ppm_cfg_t;
endpackage : ppm_pkg

// ### src/ppm_regs.sv
// power-management capability and control/status registers
`timescale 1ns/1ps
`default_nettype none

module ppm_regs (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic PCI_BUS_RESET_N,
    input wire ppm_pkg::ppm_cfg_t CFG,
    input wire logic PM_REV_SELECT,
    input wire logic WAKE_EVENT,
    output logic [31:0] RDATA,
    output logic WAKE_OUT,
    output logic SEC_CLK_STOP,
    output logic INTERNAL_RESET
);
    import ppm_pkg::*;

    // bus reset comes from a pin: two-stage synchroniser
    logic pci_bus_reset_n_s1;
    logic pci_bus_reset_n_s2;
    logic wake_s1;
    logic wake_s2;
    // stored state
    logic wake_d3cold;
    logic wake_event_enable;
    logic wake_event_status;
    ppm_pstate_t power_state_field;
    logic [15:0] caps;
    logic [15:0] csr;
    logic wr_caps;
    logic wr_csr;

    // bus reset pin; both stages idle high so that the release of the
    // global reset never looks like a bus reset to the logic below
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pci_bus_reset_n_s1 <= 1'b1;
            pci_bus_reset_n_s2 <= 1'b1;
        end else if (CE) begin
            pci_bus_reset_n_s1 <= PCI_BUS_RESET_N;
            pci_bus_reset_n_s2 <= pci_bus_reset_n_s1;
        end
    end

    // wake event from the function; costs two cycles of latency
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else if (CE) begin
            wake_s1 <= WAKE_EVENT;
            wake_s2 <= wake_s1;
        end
    end

    // true when a byte address falls in the same dword as a register offset
    function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction : word_hit

    // word decodes: caps in upper half of word A0, csr in lower half of A4
    assign wr_caps = CFG.wr && word_hit(CFG.addr, OFS_CAPS) && CFG.be[3];
    assign wr_csr = CFG.wr && word_hit(CFG.addr, OFS_CSR);

    // D3cold wake bit, global reset only; other caps bits are read-only, version follows PM_REV_SELECT
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wake_d3cold <= CAP_WAKE_D3COLD_RST;
        end else if (CE && wr_caps) begin
            wake_d3cold <= CFG.wdata[16 + CAP_WAKE_D3COLD];
        end
    end

    // enable bit ignores the bus reset
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wake_event_enable <= 1'b0;
        end else if (CE && wr_csr && CFG.be[1]) begin
            wake_event_enable <= CFG.wdata[CSR_ENABLE];
        end
    end

    // wake status: set wins over write-one clear
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wake_event_status <= 1'b0;
        end else if (CE) begin
            if (wake_s2) begin
                wake_event_status <= 1'b1;
            end else if (!pci_bus_reset_n_s2 && !wake_event_enable) begin
                // bus reset clears only when disabled
                wake_event_status <= 1'b0;
            end else if (wr_csr && CFG.be[1] && CFG.wdata[CSR_STATUS]) begin
                // write one clears, zero has no effect
                wake_event_status <= 1'b0;
            end
        end
    end

    // power state: bus reset returns to D0; the D3hot-D0 internal reset
    // leaves this register alone
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            power_state_field <= PS_D0;
        end else if (CE) begin
            if (!pci_bus_reset_n_s2) begin
                power_state_field <= PS_D0;
            end else if (wr_csr && CFG.be[0]) begin
                power_state_field <= ppm_pstate_t'(CFG.wdata[1:0]);
            end
        end
    end

    // internal reset pulse on D3hot to D0 for the rest of the function
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            INTERNAL_RESET <= 1'b0;
        end else if (CE) begin
            // pulse resets other registers; csr is exempt
            INTERNAL_RESET <= pci_bus_reset_n_s2 && wr_csr && CFG.be[0] &&
                (power_state_field == PS_D3HOT) && (CFG.wdata[1:0] == PS_D0);
        end
    end

    // read values, read-only fields derived each cycle
    always_comb begin
        caps = CAP_FIXED;
        caps[CAP_WAKE_D3COLD] = wake_d3cold;
        caps[CAP_DSI] = 1'b0;
        caps[CAP_AUX_POWER] = 1'b0;
        caps[CAP_NEEDS_CLK] = 1'b0;
        caps[2:0] = PM_REV_SELECT ? VER_REV12 : VER_REV11;
        csr = CSR_RST;
        csr[CSR_STATUS] = wake_event_status;
        csr[CSR_ENABLE] = wake_event_enable;
        csr[1:0] = power_state_field;
    end

    // registered read data; unmapped words read zero
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= 32'h0000_0000;
        end else if (CE && CFG.rd) begin
            if (word_hit(CFG.addr, OFS_CAPS)) begin
                RDATA <= {caps, 16'h0000};
            end else if (word_hit(CFG.addr, OFS_BSE)) begin
                // bus control enable one; clock-stop one
                RDATA <= {8'h00, BSE_VALUE, csr};
            end else begin
                RDATA <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            WAKE_OUT <= 1'b0;
        end else if (CE) begin
            WAKE_OUT <= wake_event_status && wake_event_enable;
        end
    end

    // control enabled, so D3hot stops clock
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            SEC_CLK_STOP <= 1'b0;
        end else if (CE) begin
            SEC_CLK_STOP <= BSE_VALUE[7] && BSE_VALUE[6] &&
                (power_state_field == PS_D3HOT);
        end
    end

    // write-one clear of the status with no event arriving
    sequence s_status_clear;
        CE && wr_csr && CFG.be[1] && CFG.wdata[CSR_STATUS] && !wake_s2;
    endsequence
    // the following cycle is clocked in
    sequence s_live_cycle;
        CE;
    endsequence
    a_clear_drops_wake: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_status_clear ##1 s_live_cycle
        |=> !WAKE_OUT)
        else $error("wake output stayed after status clear");
    a_enable_gates_wake: assert property (@(posedge CLOCK) disable iff (!NRST)
        WAKE_OUT |-> $past(wake_event_enable))
        else $error("wake output without enable");
    a_event_sets_status: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && wake_s2) |=> wake_event_status)
        else $error("status missed wake event");
    a_enable_keeps: assert property (@(posedge CLOCK) disable iff (!NRST)
        (!pci_bus_reset_n_s2 && !wr_csr) |=> wake_event_enable == $past(wake_event_enable))
        else $error("enable changed under bus reset");
    a_status_enabled_keep: assert property (@(posedge CLOCK) disable iff (!NRST)
        (wake_event_status && wake_event_enable && !wr_csr) |=> wake_event_status)
        else $error("enabled status lost");
    a_version_select: assert property (@(posedge CLOCK) disable iff (!NRST)
        caps[2:0] == (PM_REV_SELECT ? 3'b011 : 3'b010))
        else $error("version field wrong");
    // aux flag zero with wake bit clear
    a_aux_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        !caps[CAP_WAKE_D3COLD] |-> !caps[CAP_AUX_POWER])
        else $error("aux flag set without d3cold wake");
    // power state write lands next cycle
    a_state_write: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && pci_bus_reset_n_s2 && wr_csr && CFG.be[0]) |=> power_state_field == $past(CFG.wdata[1:0]))
        else $error("power state write lost");
    a_clock_stop: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && power_state_field == PS_D3HOT) |=> SEC_CLK_STOP)
        else $error("secondary clock not stopped");

    a_dsi_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        !caps[CAP_DSI])
        else $error("initialization flag set");

    a_needs_clk_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        !caps[CAP_NEEDS_CLK])
        else $error("wake needs clock flag set");

    a_data_fields_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        csr[14:9] == 6'h00)
        else $error("data scale or select not zero");

    a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        csr[7:2] == 6'h00)
        else $error("reserved control bits not zero");

    a_bus_ctl_one: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && CFG.rd && word_hit(CFG.addr, OFS_BSE)) |=> RDATA[23] && RDATA[21:16] == 6'h00)
        else $error("bridge extension enable wrong");

    a_stop_sel_one: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && CFG.rd && word_hit(CFG.addr, OFS_BSE)) |=> RDATA[22])
        else $error("clock stop select wrong");

    a_caps_write: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && wr_caps) |=> wake_d3cold == $past(CFG.wdata[16 + CAP_WAKE_D3COLD]))
        else $error("d3cold wake write lost");

    a_status_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
        s_status_clear |=> !wake_event_status)
        else $error("status not cleared by write one");

    a_bus_reset_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && !pci_bus_reset_n_s2 && !wake_event_enable && !wake_s2) |=> !wake_event_status)
        else $error("disabled status kept through bus reset");

    a_pulse_once: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && INTERNAL_RESET) |=> !INTERNAL_RESET)
        else $error("internal reset longer than one cycle");

    a_pulse_needs_d3: assert property (@(posedge CLOCK) disable iff (!NRST)
        (INTERNAL_RESET && !$past(INTERNAL_RESET)) |-> $past(power_state_field == PS_D3HOT))
        else $error("internal reset without D3hot exit");

    a_pulse_keeps_csr: assert property (@(posedge CLOCK) disable iff (!NRST)
        (INTERNAL_RESET && !wr_csr && pci_bus_reset_n_s2 && !wake_s2) |=> csr == $past(csr))
        else $error("control/status changed by internal reset");

    a_ps_bus_reset: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && !pci_bus_reset_n_s2) |=> power_state_field == PS_D0)
        else $error("power state kept through bus reset");

    a_clk_run: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && power_state_field != PS_D3HOT) |=> !SEC_CLK_STOP)
        else $error("secondary clock stopped outside D3hot");

    a_wake_follows: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && wake_event_status && wake_event_enable) |=> WAKE_OUT)
        else $error("wake output missing");

    a_enable_write: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && wr_csr && CFG.be[1]) |=> wake_event_enable == $past(CFG.wdata[CSR_ENABLE]))
        else $error("enable write lost");

    a_rdata_unmapped: assert property (@(posedge CLOCK) disable iff (!NRST)
        (CE && CFG.rd && !word_hit(CFG.addr, OFS_CAPS) && !word_hit(CFG.addr, OFS_CSR))
        |=> RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_caps_fixed: assert property (@(posedge CLOCK) disable iff (!NRST)
        caps[14:9] == 6'h3F && caps[8:6] == 3'h0)
        else $error("fixed capability bits changed");
endmodule : ppm_regs

`default_nettype wire

// ### test/ppm_host.sv
// host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module ppm_host (
    input wire logic clock,
    input wire logic [31:0] rdata,
    output var ppm_pkg::ppm_cfg_t cfg
);
    import ppm_pkg::*;
    // idle bus; stale fields are inverted so they never look like a request
    initial cfg = '{1'b0, 1'b0, 8'h00, 4'h0, 32'h5A5A_5A5A};
    // one write, held through the taking edge
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clock);
        #1 cfg = '{1'b0, 1'b1, a, b, d};
        @(posedge clock);
        #1 cfg = '{1'b0, 1'b0, ~a, 4'h0, ~d};
    endtask : cfg_wr
    // read data is registered, so sample one edge later
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clock);
        #1 cfg = '{1'b1, 1'b0, a, 4'hF, 32'h0000_0000};
        @(posedge clock);
        #1 cfg = '{1'b0, 1'b0, ~a, 4'h0, 32'hFFFF_FFFF};
        @(posedge clock);
        #1 q = rdata;
    endtask : cfg_rd
endmodule : ppm_host
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the power-management register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ppm_pkg::*;
    logic clock, nrst, ce, bus_rst_n, rev_sel, wake_ev, wake_out, clk_stop, int_rst;
    ppm_cfg_t cfg;
    logic [31:0] rdata, q;
    int err_total = 0;
    int check_count = 0;
    int n;
    ppm_host host (.clock(clock), .rdata(rdata), .cfg(cfg));
    ppm_regs DUT (.CLOCK(clock), .NRST(nrst), .CE(ce), .PCI_BUS_RESET_N(bus_rst_n),
        .CFG(cfg), .PM_REV_SELECT(rev_sel), .WAKE_EVENT(wake_ev), .RDATA(rdata),
        .WAKE_OUT(wake_out), .SEC_CLK_STOP(clk_stop), .INTERNAL_RESET(int_rst));
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // masked read compare; mask hides bits left to the designer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        host.cfg_rd(a, q);
        chk(q & m, e);
    endtask : rd_chk
    // event held past the two-stage synchroniser
    task automatic pulse_wake();
        wake_ev = 1'b1;
        cyc(4);
        wake_ev = 1'b0;
        cyc(6);
    endtask : pulse_wake
    task automatic bus_reset();
        bus_rst_n = 1'b0;
        cyc(5);
        bus_rst_n = 1'b1;
        cyc(4);
    endtask : bus_reset
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    initial begin
        nrst = 1'b0;
        bus_rst_n = 1'b1;
        rev_sel = 1'b0;
        wake_ev = 1'b0;
        ce = 1'b1;
        cyc(20);
        nrst = 1'b1;
        rd_chk(OFS_CAPS, 32'hFFEF_FFFF, 32'hFE02_0000);
        rd_chk(OFS_CSR, 32'hFFFF_FFFF, 32'h00C0_0000);
        rev_sel = 1'b1;
        // read-only caps bits ignore a full write
        host.cfg_wr(OFS_CAPS, 4'hF, 32'hFFFF_FFFF);
        rd_chk(OFS_CAPS, 32'hFFEF_FFFF, 32'hFE03_0000);
        host.cfg_wr(OFS_CAPS, 4'h8, 32'h0000_0000);
        rd_chk(OFS_CAPS, 32'hFFFF_FFFF, 32'h7E03_0000);
        // all ones: only state and enable stick, status stays clear
        host.cfg_wr(OFS_CSR, 4'hF, 32'hFFFF_FFFF);
        rd_chk(OFS_CSR, 32'hFFFF_FFFF, 32'h00C0_0103);
        chk(clk_stop, 1);
        // leaving D3hot gives exactly one internal reset pulse
        host.cfg_wr(OFS_CSR, 4'h1, 32'h0000_0000);
        n = 0;
        repeat (4) begin
            if (int_rst === 1'b1) n++;
            cyc(1);
        end
        chk(n, 1);
        rd_chk(OFS_CSR, 32'hFFFF_FFFF, 32'h00C0_0100);
        chk(clk_stop, 0);
        for (int s = 1; s < 3; s++) begin
            host.cfg_wr(OFS_CSR, 4'h1, s);
            rd_chk(OFS_CSR, 32'h0000_0003, s);
        end
        // clock enable low: a write must be frozen out
        ce = 1'b0;
        host.cfg_wr(OFS_CSR, 4'h1, 32'h0000_0003);
        ce = 1'b1;
        rd_chk(OFS_CSR, 32'h0000_0003, 32'h0000_0002);
        rd_chk(8'hB0, 32'hFFFF_FFFF, 32'h0000_0000);
        pulse_wake();
        chk(wake_out, 1);
        // writing zero to status keeps it
        host.cfg_wr(OFS_CSR, 4'h2, 32'h0000_0100);
        rd_chk(OFS_CSR, 32'h0000_FF00, 32'h0000_8100);
        host.cfg_wr(OFS_CSR, 4'h2, 32'h0000_8100);
        rd_chk(OFS_CSR, 32'h0000_FF00, 32'h0000_0100);
        chk(wake_out, 0);
        // bus reset with wake enabled keeps status and enable
        pulse_wake();
        bus_reset();
        rd_chk(OFS_CSR, 32'hFFFF_FFFF, 32'h00C0_8100);
        // disabled: status still sets, output stays low
        host.cfg_wr(OFS_CSR, 4'h2, 32'h0000_8000);
        pulse_wake();
        chk(wake_out, 0);
        rd_chk(OFS_CSR, 32'h0000_FF00, 32'h0000_8000);
        bus_reset();
        rd_chk(OFS_CSR, 32'h0000_FF00, 32'h0000_0000);
        // global reset clears the enable
        host.cfg_wr(OFS_CSR, 4'h2, 32'h0000_0100);
        nrst = 1'b0;
        cyc(2);
        nrst = 1'b1;
        rd_chk(OFS_CSR, 32'h0000_FF00, 32'h0000_0000);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
